// ==== inc/tlbe_params.svh ====
// Constants for the TLB entry staging registers
`ifndef TLBE_PARAMS_SVH
`define TLBE_PARAMS_SVH

`define TLBE_NENT 32
`define TLBE_IDX_W 5
`define TLBE_VIRTUAL_PAIR_NUMBER_W 29
`define TLBE_FRAME_W 22
`define TLBE_ATTR_W 3
`define TLBE_MASK_W 8
`define TLBE_TAG_W 8
`define TLBE_SPACE_W 2
`define TLBE_VA_W 40
`define TLBE_PA_W 32
`define TLBE_RNUM_W 5

`define TLBE_OFS_EPTR 5'h00
`define TLBE_OFS_RPTR 5'h01
`define TLBE_OFS_EVEN 5'h02
`define TLBE_OFS_ODD 5'h03
`define TLBE_OFS_PSIZE 5'h05

`define TLBE_MISS_BIT 31
`define TLBE_IDX_HI 4
`define TLBE_FRAME_HI 27
`define TLBE_FRAME_LO 6
`define TLBE_ATTR_HI 5
`define TLBE_ATTR_LO 3
`define TLBE_WP_BIT 2
`define TLBE_OK_BIT 1
`define TLBE_GLB_BIT 0
`define TLBE_MASK_HI 18
`define TLBE_MASK_LO 11
`define TLBE_VIRTUAL_PAIR_NUMBER_LO 11
`define TLBE_VIRTUAL_PAIR_NUMBER_HI 39
`define TLBE_PAGE_SHIFT 10

`define TLBE_RPTR_TOP 5'h1f
`define TLBE_FLOOR_RST 5'h00
`define TLBE_ATTR_UNCACHED 3'h2

`endif

// ==== inc/tlbe_pkg.sv ====
// Types shared by the TLB entry staging logic
`include "tlbe_params.svh"

package tlbe_pkg;

    typedef struct packed {
        logic [`TLBE_FRAME_W-1:0] frame_number;
        logic [`TLBE_ATTR_W-1:0] page_attr;
        logic write_permit;
        logic entry_ok;
    } tlbe_half_t;

    typedef struct packed {
        logic [`TLBE_MASK_W-1:0] mask;
        logic [`TLBE_SPACE_W-1:0] space_type;
        logic [`TLBE_VIRTUAL_PAIR_NUMBER_W-1:0] virtual_pair_number;
        logic glb;
        logic [`TLBE_TAG_W-1:0] space_tag;
        tlbe_half_t even;
        tlbe_half_t odd;
    } tlbe_entry_t;

    typedef struct packed {
        logic [`TLBE_SPACE_W-1:0] space_type;
        logic [`TLBE_VIRTUAL_PAIR_NUMBER_W-1:0] virtual_pair_number;
        logic [`TLBE_TAG_W-1:0] space_tag;
    } tlbe_key_t;

    typedef enum logic [2:0] {
        TLBE_OP_NONE,
        TLBE_OP_PROBE,
        TLBE_OP_READ,
        TLBE_OP_WIDX,
        TLBE_OP_WREP
    } tlbe_op_t;

endpackage : tlbe_pkg

// ==== inc/tlbe_cmp_if.sv ====
// Key, entry array and match result between the top and a comparator
`timescale 1ns/1ps
`include "tlbe_params.svh"

interface tlbe_cmp_if;
    tlbe_pkg::tlbe_key_t key;
    tlbe_pkg::tlbe_entry_t entries [`TLBE_NENT];
    logic hit;
    logic [`TLBE_IDX_W-1:0] hit_idx;

    modport req (output key, output entries, input hit, input hit_idx);
    modport cmp (input key, input entries, output hit, output hit_idx);
endinterface : tlbe_cmp_if

// ==== rtl/tlbe_match.sv ====
// Parallel tag comparator over all TLB entries
`timescale 1ns/1ps
`include "tlbe_params.svh"

module tlbe_match (
    tlbe_cmp_if.cmp m
);

    function automatic logic entry_hits(
        input tlbe_pkg::tlbe_entry_t e,
        input tlbe_pkg::tlbe_key_t k
    );
        logic [`TLBE_VIRTUAL_PAIR_NUMBER_W-1:0] care;
        care = ~{{(`TLBE_VIRTUAL_PAIR_NUMBER_W-`TLBE_MASK_W){1'b0}}, e.mask};
        // [RQ14] masked bits skipped
        entry_hits = (e.space_type == k.space_type)
            && (((e.virtual_pair_number ^ k.virtual_pair_number) & care)
                == '0)
            // [RQ12] global ignores tag
            && (e.glb || (e.space_tag == k.space_tag));
    endfunction : entry_hits

    // Lowest index wins; duplicate matches are a software fault
    always_comb
    begin
        m.hit = 1'b0;
        m.hit_idx = '0;
        for (int i = `TLBE_NENT - 1; i >= 0; i--)
        begin
            if (entry_hits(m.entries[i], m.key))
            begin
                m.hit = 1'b1;
                m.hit_idx = i[`TLBE_IDX_W-1:0];
            end
        end
    end

endmodule : tlbe_match

// ==== rtl/tlbe_top.sv ====
// TLB staging registers, entry array, probe and translation
// Overview of operation
// [RQ1] Entry pointer is 32 bits; five-bit index picks one entry.
// [RQ2] Top bit of entry pointer is set on probe miss, cleared on hit.
// [RQ3] Entry read and indexed write use the entry pointer index.
// [RQ4] Reserved bits are written zero by software and read as zero.
// [RQ5] Replace pointer is read-only and steps down once per instruction.
// [RQ6] Replace pointer stays between the locked floor and 31.
// [RQ7] Replace pointer loads 31 on reset and on locked floor write.
// [RQ8] Replacement write targets the entry at the replace pointer.
// [RQ9] Even and odd map registers carry the two entry halves.
// [RQ10] Write permit clear protects the page against stores.
// [RQ11] Entry ok clear on a match raises an invalid exception.
// [RQ12] Global in both halves makes lookup ignore the space tag.
// [RQ13] Attribute value 2 is uncacheable, all others cacheable.
// [RQ14] Mask bits exclude address bits 18 to 11 from comparison.
// [RQ15] Page sizes 1K to 256K use 0, 2, 4, 6 or 8 mask bits.
// [RQ16] Software programs only listed mask patterns.
// [RQ17] Page size register is source and destination of entry moves.
// [RQ18] Entry holds mask, space type, pair number, global, tag, halves.
// [RQ19] Replacement write never lands below the locked floor.
// [RQ20] Locked floor clears to zero on reset.
// [RQ21] Decrement at the lower bound wraps to 31.
// [RQ22] The TLB holds 32 entries.
`timescale 1ns/1ps
`include "tlbe_params.svh"

module tlbe_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`TLBE_RNUM_W-1:0] reg_num,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic instr_retire,
    input wire logic floor_wr,
    input wire logic [`TLBE_IDX_W-1:0] floor_val,
    input wire logic [`TLBE_SPACE_W-1:0] vtag_space,
    input wire logic [`TLBE_VIRTUAL_PAIR_NUMBER_W-1:0] vtag_virtual_pair_number,
    input wire logic [`TLBE_TAG_W-1:0] vtag_tag,
    input wire logic op_probe,
    input wire logic op_read,
    input wire logic op_write_idx,
    input wire logic op_write_rep,
    output logic rd_valid,
    output logic [`TLBE_SPACE_W-1:0] rd_space,
    output logic [`TLBE_VIRTUAL_PAIR_NUMBER_W-1:0] rd_virtual_pair_number,
    output logic [`TLBE_TAG_W-1:0] rd_tag,
    input wire logic xl_req,
    input wire logic [`TLBE_VA_W-1:0] xl_va,
    input wire logic [`TLBE_SPACE_W-1:0] xl_space,
    input wire logic [`TLBE_TAG_W-1:0] xl_tag,
    input wire logic xl_store,
    output logic xl_done,
    output logic xl_miss,
    output logic xl_invalid,
    output logic xl_protect,
    output logic xl_uncached,
    output logic [`TLBE_PA_W-1:0] xl_pa
);

    // [RQ22] 32 entries
    // [RQ18] full entry layout
    tlbe_pkg::tlbe_entry_t tlb_r [`TLBE_NENT];

    logic miss_r;
    logic [`TLBE_IDX_W-1:0] idx_r;
    logic [`TLBE_IDX_W-1:0] rep_r;
    logic [`TLBE_IDX_W-1:0] floor_r;
    tlbe_pkg::tlbe_half_t even_r;
    tlbe_pkg::tlbe_half_t odd_r;
    logic even_g_r;
    logic odd_g_r;
    logic [`TLBE_MASK_W-1:0] mask_r;
    tlbe_pkg::tlbe_op_t op;
    tlbe_pkg::tlbe_entry_t wr_entry;
    tlbe_pkg::tlbe_entry_t xl_ent;
    tlbe_pkg::tlbe_half_t xl_half;
    logic [4:0] odd_pos;
    logic [`TLBE_PA_W-1:0] off_mask;

    tlbe_cmp_if probe_if ();
    tlbe_cmp_if xl_if ();

    function automatic tlbe_pkg::tlbe_half_t map_unpack(
        input logic [31:0] w
    );
        tlbe_pkg::tlbe_half_t h;
        h.frame_number = w[`TLBE_FRAME_HI:`TLBE_FRAME_LO];
        h.page_attr = w[`TLBE_ATTR_HI:`TLBE_ATTR_LO];
        h.write_permit = w[`TLBE_WP_BIT];
        h.entry_ok = w[`TLBE_OK_BIT];
        return h;
    endfunction : map_unpack

    // [RQ4] reserved bits read zero
    function automatic logic [31:0] map_pack(
        input tlbe_pkg::tlbe_half_t h,
        input logic g
    );
        logic [31:0] w;
        w = '0;
        w[`TLBE_FRAME_HI:`TLBE_FRAME_LO] = h.frame_number;
        w[`TLBE_ATTR_HI:`TLBE_ATTR_LO] = h.page_attr;
        w[`TLBE_WP_BIT] = h.write_permit;
        w[`TLBE_OK_BIT] = h.entry_ok;
        w[`TLBE_GLB_BIT] = g;
        return w;
    endfunction : map_pack

    // [RQ21] wrap at the lower bound
    function automatic logic [`TLBE_IDX_W-1:0] rep_step(
        input logic [`TLBE_IDX_W-1:0] cur,
        input logic [`TLBE_IDX_W-1:0] flr
    );
        if (cur == flr || cur == '0)
            rep_step = `TLBE_RPTR_TOP;
        else
            rep_step = cur - 1'b1;
    endfunction : rep_step

    function automatic logic [4:0] ones(
        input logic [`TLBE_MASK_W-1:0] m
    );
        logic [4:0] n;
        n = '0;
        for (int i = 0; i < `TLBE_MASK_W; i++)
            n = n + {4'h0, m[i]};
        return n;
    endfunction : ones

    // Instruction decode; the core never issues two at once
    always_comb
    begin
        if (op_probe)
            op = tlbe_pkg::TLBE_OP_PROBE;
        else if (op_read)
            op = tlbe_pkg::TLBE_OP_READ;
        else if (op_write_idx)
            op = tlbe_pkg::TLBE_OP_WIDX;
        else if (op_write_rep)
            op = tlbe_pkg::TLBE_OP_WREP;
        else
            op = tlbe_pkg::TLBE_OP_NONE;
    end

    // [RQ17] page size is the write source
    always_comb
    begin
        wr_entry.mask = mask_r;
        wr_entry.space_type = vtag_space;
        wr_entry.virtual_pair_number = vtag_virtual_pair_number;
        // [RQ12] global only when set in both halves
        wr_entry.glb = even_g_r & odd_g_r;
        wr_entry.space_tag = vtag_tag;
        wr_entry.even = even_r;
        wr_entry.odd = odd_r;
    end

    assign probe_if.key = '{vtag_space, vtag_virtual_pair_number, vtag_tag};
    assign probe_if.entries = tlb_r;
    assign xl_if.key = '{xl_space,
        xl_va[`TLBE_VIRTUAL_PAIR_NUMBER_HI:`TLBE_VIRTUAL_PAIR_NUMBER_LO], xl_tag};
    assign xl_if.entries = tlb_r;

    tlbe_match u_probe (
        .m(probe_if.cmp)
    );

    tlbe_match u_xl (
        .m(xl_if.cmp)
    );

    // Entry array writes
    always_ff @(posedge core_clk)
    begin
        case (op)
            // [RQ3] indexed write
            tlbe_pkg::TLBE_OP_WIDX:
                tlb_r[idx_r] <= wr_entry;
            // [RQ8] write at replace pointer
            tlbe_pkg::TLBE_OP_WREP:
            begin
                // [RQ19] floor guard
                if (rep_r >= floor_r)
                    tlb_r[rep_r] <= wr_entry;
            end
            default:
                ;
        endcase
    end

    // Entry pointer: software index and probe result
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            miss_r <= 1'b0;
            idx_r <= '0;
        end
        else if (op == tlbe_pkg::TLBE_OP_PROBE)
        begin
            // [RQ2] miss flag from probe
            miss_r <= ~probe_if.hit;
            if (probe_if.hit)
                idx_r <= probe_if.hit_idx;
        end
        else if (reg_wr && reg_num == `TLBE_OFS_EPTR)
            // [RQ1] only the index field is writable
            idx_r <= reg_wdata[`TLBE_IDX_HI:0];
    end

    // Locked floor copy and replace pointer
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            // [RQ20] floor cleared
            floor_r <= `TLBE_FLOOR_RST;
            // [RQ7] top on reset
            rep_r <= `TLBE_RPTR_TOP;
        end
        else if (floor_wr)
        begin
            floor_r <= floor_val;
            // [RQ7] top on floor write
            rep_r <= `TLBE_RPTR_TOP;
        end
        else if (instr_retire)
            // [RQ5] [RQ6] step down within bounds
            rep_r <= rep_step(rep_r, floor_r);
    end

    // Map and page size registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            even_r <= '0;
            odd_r <= '0;
            even_g_r <= 1'b0;
            odd_g_r <= 1'b0;
            mask_r <= '0;
        end
        else if (op == tlbe_pkg::TLBE_OP_READ)
        begin
            // [RQ9] [RQ3] [RQ17] load halves and mask
            even_r <= tlb_r[idx_r].even;
            odd_r <= tlb_r[idx_r].odd;
            even_g_r <= tlb_r[idx_r].glb;
            odd_g_r <= tlb_r[idx_r].glb;
            mask_r <= tlb_r[idx_r].mask;
        end
        else if (reg_wr)
        begin
            case (reg_num)
                `TLBE_OFS_EVEN:
                begin
                    // [RQ9] even half
                    even_r <= map_unpack(reg_wdata);
                    even_g_r <= reg_wdata[`TLBE_GLB_BIT];
                end
                `TLBE_OFS_ODD:
                begin
                    // [RQ9] odd half
                    odd_r <= map_unpack(reg_wdata);
                    odd_g_r <= reg_wdata[`TLBE_GLB_BIT];
                end
                // [RQ15] [RQ16] pattern stored as given
                `TLBE_OFS_PSIZE:
                    mask_r <= reg_wdata[`TLBE_MASK_HI:`TLBE_MASK_LO];
                default:
                    ;
            endcase
        end
    end

    // Register read port; unmapped numbers read zero
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            reg_rdata <= '0;
            case (reg_num)
                `TLBE_OFS_EPTR:
                begin
                    reg_rdata[`TLBE_MISS_BIT] <= miss_r;
                    reg_rdata[`TLBE_IDX_HI:0] <= idx_r;
                end
                `TLBE_OFS_RPTR:
                    reg_rdata[`TLBE_IDX_HI:0] <= rep_r;
                `TLBE_OFS_EVEN:
                    reg_rdata <= map_pack(even_r, even_g_r);
                `TLBE_OFS_ODD:
                    reg_rdata <= map_pack(odd_r, odd_g_r);
                `TLBE_OFS_PSIZE:
                    reg_rdata[`TLBE_MASK_HI:`TLBE_MASK_LO] <= mask_r;
                default:
                    ;
            endcase
        end
    end

    // Virtual tag read-back toward the tag register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rd_valid <= 1'b0;
            rd_space <= '0;
            rd_virtual_pair_number <= '0;
            rd_tag <= '0;
        end
        else
        begin
            rd_valid <= (op == tlbe_pkg::TLBE_OP_READ);
            if (op == tlbe_pkg::TLBE_OP_READ)
            begin
                rd_space <= tlb_r[idx_r].space_type;
                rd_virtual_pair_number <= tlb_r[idx_r].virtual_pair_number;
                rd_tag <= tlb_r[idx_r].space_tag;
            end
        end
    end

    // Odd page select bit moves up with the page size
    always_comb
    begin
        xl_ent = tlb_r[xl_if.hit_idx];
        // [RQ15] select bit from mask width
        odd_pos = 5'(`TLBE_PAGE_SHIFT) + ones(xl_ent.mask);
        xl_half = xl_va[odd_pos] ? xl_ent.odd : xl_ent.even;
        off_mask = `TLBE_PA_W'((`TLBE_VA_W'(1) << odd_pos) - 1'b1);
    end

    // Translation result, one cycle after the request
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            xl_done <= 1'b0;
            xl_miss <= 1'b0;
            xl_invalid <= 1'b0;
            xl_protect <= 1'b0;
            xl_uncached <= 1'b0;
            xl_pa <= '0;
        end
        else
        begin
            xl_done <= xl_req;
            if (xl_req)
            begin
                xl_miss <= ~xl_if.hit;
                // [RQ11] invalid exception
                xl_invalid <= xl_if.hit & ~xl_half.entry_ok;
                // [RQ10] store to protected page
                xl_protect <= xl_if.hit & xl_half.entry_ok & xl_store
                    & ~xl_half.write_permit;
                // [RQ13] attribute 2 uncached
                xl_uncached <= (xl_half.page_attr == `TLBE_ATTR_UNCACHED);
                xl_pa <= ({xl_half.frame_number, `TLBE_PAGE_SHIFT'(0)}
                    & ~off_mask) | (xl_va[`TLBE_PA_W-1:0] & off_mask);
            end
        end
    end

endmodule : tlbe_top

// ==== tb/tlbe_top_assertions.sv ====
// Port-level checks for the TLB staging registers
`timescale 1ns/1ps

module tlbe_top_assertions (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic [4:0] reg_num,
    input wire logic [31:0] reg_rdata,
    input wire logic floor_wr,
    input wire logic [4:0] floor_val,
    input wire logic op_probe,
    input wire logic op_read,
    input wire logic rd_valid,
    input wire logic xl_req,
    input wire logic xl_store,
    input wire logic xl_miss,
    input wire logic xl_invalid,
    input wire logic xl_protect
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Shadow of the locked floor, the lower bound seen from outside
    logic [4:0] floor_r;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            floor_r <= 5'h00;
        else if (floor_wr)
            floor_r <= floor_val;
    end

    sequence s_floor_rd;
        floor_wr ##1 (reg_rd && reg_num == 5'h01);
    endsequence

    sequence s_read_op;
        op_read && !op_probe;
    endsequence

    a_rptr_reserved: assert property (reg_rd && reg_num == 5'h01
        |=> reg_rdata[31:5] == 27'h0) else $error("replace ptr high bits");
    a_eptr_reserved: assert property (reg_rd && reg_num == 5'h00
        |=> reg_rdata[30:5] == 26'h0) else $error("entry ptr reserved");
    a_map_reserved: assert property (reg_rd && reg_num inside {2, 3}
        |=> reg_rdata[31:28] == 4'h0) else $error("map reserved bits");
    a_mask_reserved: assert property (reg_rd && reg_num == 5'h05
        |=> reg_rdata[31:19] == 13'h0 && reg_rdata[10:0] == 11'h0)
        else $error("page size reserved bits");
    a_unmapped_zero: assert property (reg_rd && reg_num == 5'h04
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    a_floor_load: assert property (s_floor_rd |=> reg_rdata == 32'h1f)
        else $error("replace ptr not at top after floor write");
    a_rptr_range: assert property (reg_rd && reg_num == 5'h01
        && !floor_wr |=> reg_rdata[4:0] >= floor_r)
        else $error("replace ptr below floor");
    a_read_valid: assert property (s_read_op |=> rd_valid)
        else $error("entry read gave no valid");
    a_valid_cause: assert property (rd_valid |-> $past(op_read))
        else $error("valid without entry read");
    a_store_protect: assert property (xl_req && !xl_store
        |=> !xl_protect) else $error("protect on a load");
    a_invalid_hit: assert property (xl_invalid
        |-> !xl_miss && !xl_protect) else $error("invalid with miss");
endmodule : tlbe_top_assertions

bind tlbe_top tlbe_top_assertions u_chk (
    .core_clk, .rst_n, .reg_rd, .reg_num, .reg_rdata, .floor_wr,
    .floor_val, .op_probe, .op_read, .rd_valid, .xl_req, .xl_store,
    .xl_miss, .xl_invalid, .xl_protect
);

// ==== tb/tlbe_top_tb.sv ====
// Self-checking bench for the TLB staging registers
`timescale 1ns/1ps

module tlbe_top_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, instr_retire = 1'b0;
    logic floor_wr = 1'b0, xl_req = 1'b0, xl_store = 1'b0;
    logic [4:0] reg_num = 5'h00, floor_val = 5'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, xl_pa;
    logic [3:0] ops = 4'h0;
    logic [1:0] vtag_space = 2'h0, xl_space = 2'h0, rd_space;
    logic [28:0] vtag_virtual_pair_number = 29'h0, rd_virtual_pair_number;
    logic [7:0] vtag_tag = 8'h5a, xl_tag = 8'h5a, rd_tag;
    logic [39:0] xl_va = 40'h0;
    logic rd_valid, xl_done, xl_miss, xl_invalid, xl_protect, xl_uncached;
    int mismatches = 0, n_tests = 0;
    // Low pair bits clear so the 4K mask hides only zeros
    localparam logic [28:0] vp = 29'h0abc_d000;
    localparam logic [31:0] ev = 32'h0048_d013;
    localparam logic [31:0] od = 32'h0002_af1c;
    localparam logic [31:0] msk = 32'h0000_1800;

    tlbe_top DUT (
        .core_clk, .rst_n, .reg_wr, .reg_rd, .reg_num, .reg_wdata,
        .reg_rdata, .instr_retire, .floor_wr, .floor_val, .vtag_space,
        .vtag_virtual_pair_number, .vtag_tag, .op_probe(ops[0]), .op_read(ops[1]),
        .op_write_idx(ops[2]), .op_write_rep(ops[3]), .rd_valid,
        .rd_space, .rd_virtual_pair_number, .rd_tag, .xl_req, .xl_va, .xl_space,
        .xl_tag, .xl_store, .xl_done, .xl_miss, .xl_invalid,
        .xl_protect, .xl_uncached, .xl_pa
    );

    initial
    begin
        forever #25 core_clk = ~core_clk;
    end

    task test_done;
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    task chk(string nm, logic [31:0] s, logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task wr(logic [4:0] n, logic [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_num <= n;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(logic [4:0] n, logic [31:0] e, string nm,
            logic [31:0] m = 32'hffff_ffff);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_num <= n;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata & m, e & m);
    endtask : rd

    task op(int k);
        @(posedge core_clk);
        ops <= 4'h1 << k;
        @(posedge core_clk);
        ops <= 4'h0;
        #1;
    endtask : op

    task ret(int n);
        @(posedge core_clk);
        instr_retire <= 1'b1;
        repeat (n) @(posedge core_clk);
        instr_retire <= 1'b0;
    endtask : ret

    // Read issued right behind the floor write to catch the reload
    task flr(logic [4:0] v);
        @(posedge core_clk);
        floor_wr <= 1'b1;
        floor_val <= v;
        @(posedge core_clk);
        floor_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_num <= 5'h01;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("replace_pointer", reg_rdata, 32'h1f);
    endtask : flr

    task ent(logic [4:0] i, logic [28:0] v, logic [31:0] e,
             logic [31:0] o, logic [31:0] m);
        wr(5'h00, {27'h0, i});
        wr(5'h02, e);
        wr(5'h03, o);
        wr(5'h05, m);
        @(posedge core_clk);
        vtag_virtual_pair_number <= v;
        op(2);
    endtask : ent

    // On a miss only the miss flag is defined
    task xl(logic [39:0] va, logic st, logic [7:0] tg, logic [3:0] ef,
            logic [31:0] ep);
        logic [3:0] m;
        m = ef[3] ? 4'h8 : 4'hf;
        @(posedge core_clk);
        xl_req <= 1'b1;
        xl_va <= va;
        xl_store <= st;
        xl_tag <= tg;
        @(posedge core_clk);
        xl_req <= 1'b0;
        #1 chk("xl_flags", 32'(m & {xl_miss, xl_invalid, xl_protect,
            xl_uncached}), 32'(m & ef));
        chk("xl_done", 32'(xl_done), 32'h1);
        if (ef[3:1] == 3'h0)
            chk("xl_pa", xl_pa, ep);
    endtask : xl

    initial
    begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        test_done;
    end

    initial
    begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(5'h01, 32'h1f, "replace_pointer");
        rd(5'h00, 32'h0, "entry_pointer");
        rd(5'h04, 32'h0, "unmapped");
        wr(5'h00, 32'hffff_ffff);
        rd(5'h00, 32'h1f, "entry_pointer");
        wr(5'h01, 32'h0);
        rd(5'h01, 32'h1f, "replace_pointer");
        ret(3);
        rd(5'h01, 32'h1c, "replace_pointer");
        flr(5'h1e);
        ret(2);
        rd(5'h01, 32'h1f, "replace_pointer");
        wr(5'h02, 32'hffff_ffff);
        rd(5'h02, 32'h0fff_ffff, "even_map");
        wr(5'h05, 32'hffff_ffff);
        rd(5'h05, 32'h0007_f800, "page_size");
        for (int i = 0; i < 32; i++)
            ent(5'(i), 29'h100 + 29'(i), 32'h0, 32'h0, 32'h0);
        ent(5'h03, vp, ev, od, msk);
        wr(5'h02, 32'h0);
        wr(5'h03, 32'h0);
        wr(5'h05, 32'h0);
        op(1);
        chk("rd_valid", 32'(rd_valid), 32'h1);
        chk("rd_virtual_pair_number", 32'(rd_virtual_pair_number), 32'(vp));
        chk("rd_tag", 32'(rd_tag), 32'h5a);
        chk("rd_space", 32'(rd_space), 32'h0);
        rd(5'h02, ev & ~32'h1, "even_map");
        rd(5'h03, od, "odd_map");
        rd(5'h05, msk, "page_size");
        @(posedge core_clk);
        vtag_virtual_pair_number <= vp | 29'h2;
        op(0);
        rd(5'h00, 32'h3, "entry_pointer");
        @(posedge core_clk);
        vtag_virtual_pair_number <= 29'h1555_5555;
        op(0);
        rd(5'h00, 32'h8000_0000, "miss_flag", 32'h8000_0000);
        xl({vp, 11'h123}, 1'b0, 8'h5a, 4'h1, 32'h048d_0123);
        xl({vp, 11'h123}, 1'b1, 8'h5a, 4'h3, 32'h0);
        xl({vp | 29'h2, 11'h0}, 1'b0, 8'h5a, 4'h4, 32'h0);
        xl({vp | 29'h1, 11'h7ff}, 1'b0, 8'h5a, 4'h1, 32'h048d_0fff);
        xl({vp, 11'h0}, 1'b0, 8'h33, 4'h8, 32'h0);
        // Wrong space type must miss even with the right tag
        @(posedge core_clk);
        xl_space <= 2'h1;
        xl({vp, 11'h0}, 1'b0, 8'h5a, 4'h8, 32'h0);
        @(posedge core_clk);
        xl_space <= 2'h0;
        wr(5'h02, 32'h43);
        wr(5'h03, 32'h43);
        // 1K page, so the frame's low bits reach the address
        wr(5'h05, 32'h0);
        @(posedge core_clk);
        vtag_virtual_pair_number <= 29'h0777_0000;
        op(3);
        xl({29'h0777_0000, 11'h5}, 1'b0, 8'h33, 4'h0, 32'h405);
        wr(5'h00, 32'h1f);
        op(1);
        chk("rd_virtual_pair_number", 32'(rd_virtual_pair_number), 32'h0777_0000);
        for (int a = 0; a < 8; a++)
        begin
            ent(5'h03, vp, 32'h0048_d003 | (32'(a) << 3), od, msk);
            xl({vp, 11'h0}, 1'b0, 8'h5a, 4'(a == 2), 32'h048d_0000);
        end
        test_done;
    end
endmodule : tlbe_top_tb
